/* File: utxf_pkg.sv */
// Shared constants for the serial transmitter and frame-format block.
// Assumes a single 125 MHz system clock and an APB register port.
package utxf_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_FIRST = 8'h04;
    localparam logic [7:0] OFS_SECOND = 8'h08;
    localparam logic [7:0] OFS_THIRD = 8'h0C;
    localparam logic [7:0] OFS_BAUD_LOW = 8'h10;
    localparam logic [7:0] OFS_BAUD_HIGH = 8'h14;
    // First control/status register fields
    localparam int BIT_TXC = 6;
    localparam int BIT_BUF_EMPTY = 5;
    localparam int BIT_DOUBLE = 1;
    // Second control register fields
    localparam int BIT_TXC_IE = 6;
    localparam int BIT_BUF_IE = 5;
    localparam int BIT_TX_EN = 3;
    localparam int BIT_SIZE2 = 2;
    localparam int BIT_NINTH = 0;
    // Third control register fields
    localparam int BIT_MASTER = 7;
    localparam int BIT_SYNC = 6;
    localparam int BIT_PAR_EN = 5;
    localparam int BIT_PAR_ODD = 4;
    localparam int BIT_STOP2 = 3;
    localparam int BIT_SIZE_HI = 2;
    localparam int BIT_SIZE_LO = 1;
    localparam int BIT_POL = 0;
    // Reset values
    localparam logic [7:0] RST_SECOND = 8'h00;
    localparam logic [7:0] RST_THIRD = 8'h06;
    localparam logic [11:0] RST_BAUD = 12'h000;
    // Character size codes
    localparam logic [2:0] SIZE_5 = 3'h0;
    localparam logic [2:0] SIZE_6 = 3'h1;
    localparam logic [2:0] SIZE_7 = 3'h2;
    localparam logic [2:0] SIZE_8 = 3'h3;
    localparam logic [2:0] SIZE_9 = 3'h7;
    // Baud ticks per bit, less one
    localparam logic [3:0] TICKS_NORMAL = 4'hF;
    localparam logic [3:0] TICKS_DOUBLE = 4'h7;
    localparam logic [3:0] TICKS_SYNC = 4'h1;
    // Transmit sequencer states, Gray along the frame
    typedef enum logic [2:0] {
        TX_IDLE = 3'h0,
        TX_START = 3'h1,
        TX_DATA = 3'h3,
        TX_PARITY = 3'h2,
        TX_STOP1 = 3'h6,
        TX_STOP2 = 3'h7
    } utxf_state_t;
endpackage

/* File: utxf_baud_gen.sv */
// Baud-rate down-counter producing one tick per reload from zero.
// Assumes the divisor and reload strobe come from the same clock domain.
`timescale 1ns/100ps
`default_nettype none
module utxf_baud_gen #(
    parameter int WIDTH = 12
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Divisor and reload on low-byte write
    input wire logic [WIDTH-1:0] divisor,
    input wire logic reload,
    // Tick out
    output logic tick
);
    logic [WIDTH-1:0] count_reg;

    // Count down, reload on zero or on a low-byte write
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            count_reg <= '0;
            tick <= 1'b0;
        end else if (reload || count_reg == '0) begin
            count_reg <= divisor; // RL27
            tick <= (count_reg == '0); // RL27
        end else begin
            count_reg <= count_reg - 1'b1;
            tick <= 1'b0;
        end
    end

    property p_tickOnZero;
        @(posedge sys_clk) disable iff (!rst_n)
        (count_reg == '0 && !reload) |=> tick;
    endproperty
    a_tickOnZero: assert property (p_tickOnZero) else $error("baud tick missing at zero"); // RL27
endmodule
`default_nettype wire

/* File: utxf_top.sv */
// Serial transmitter with frame-format control, parity and APB registers.
// Assumes an APB master on sys_clk; serial pins are asynchronous to it.
`timescale 1ns/100ps
`default_nettype none
// Operation
// [RL1] Each frame opens with one low start bit.
// [RL2] Stop bits are high; the line idles high between frames.
// [RL3] Size, parity and stop settings are one shared frame configuration.
// [RL4] Software leaves frame settings alone while a transfer runs.
// [RL5] One stop bit when stop select is clear, two when set.
// [RL6] Receiver checks only the first stop bit for frame errors.
// [RL7] Parity is XOR of data bits, inverted for odd parity.
// [RL8] With parity enabled the parity bit follows the last data bit.
// [RL9] Data bits are numbered 0 to 8, up to nine bits.
// [RL10] Transmit enable hands the output pin to the transmitter.
// [RL11] In synchronous mode the clock pin times the transmission.
// [RL12] Writing the data register fills the buffer and starts sending.
// [RL13] Buffer moves to shifter when idle or right after the last stop.
// [RL14] Unused upper data bits are ignored for short characters.
// [RL15] For nine-bit characters software writes the ninth bit first.
// [RL16] Buffer-empty flag is set while the buffer holds nothing.
// [RL17] Buffer-empty request stays high while enabled and flag set.
// [RL18] Transmit-complete sets when the frame is out and buffer empty.
// [RL19] Transmit-complete clears on interrupt service or a written one.
// [RL20] Transmit-complete request rises with the flag when enabled.
// [RL21] Disabling waits until shifter and buffer are empty, then releases pin.
// [RL22] Software writes zero to the buffer-empty bit position.
// [RL23] Software sets the select bit when writing the third register.
// [RL24] Data bits go out least significant first.
// [RL25] Bit rate is baud tick divided by 16, 8 or 2.
// [RL26] Synchronous data changes on rising clock when polarity clear.
// [RL27] Baud counter reloads on zero or low-byte write, one tick each; the code ticks only on reloads from zero.
// [RL28] Lower parity bit selects odd when set, even when clear.
module utxf_top
    import utxf_pkg::*;
#(
    parameter int BAUD_WIDTH = 12
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt requests and service acknowledge
    output logic bufEmptyIrq,
    output logic txCompleteIrq,
    input wire logic txCompleteAck,
    // Serial output pin
    output logic txdOut,
    output logic txdOe,
    // External clock pin
    input wire logic xckIn,
    output logic xckOut,
    output logic xckOe
);
    // Control registers
    logic doubleSpeed_reg;
    logic [7:0] second_reg;
    logic [7:0] third_reg;
    logic [BAUD_WIDTH-1:0] baud_reg;
    // Transmit state
    logic [8:0] buf_reg;
    logic bufFull_reg;
    logic txcFlag_reg;
    logic txOn_reg;
    utxf_state_t txState;
    logic [8:0] shift_reg;
    logic [3:0] bitCnt_reg;
    logic parityBit_reg;
    logic [3:0] presc_reg;
    logic xckS1_reg;
    logic xckS2_reg;
    logic xckS3_reg;
    logic baudTick;
    // Decoded settings
    logic [2:0] charSize;
    logic [3:0] dataBits;
    logic [8:0] dataMask;
    logic [8:0] maskedBuf;
    logic syncMode;
    logic syncMaster;
    logic clockPol;
    logic parityEn;
    logic parityOdd;
    logic stopTwo;
    logic [3:0] ticksPerBit;
    logic bitEn;
    logic loadNow;
    logic frameEnd;
    logic apbWrite;
    logic [7:0] rdValue;
    logic addrHit;

    // Shared frame configuration fields
    assign charSize = {second_reg[BIT_SIZE2], third_reg[BIT_SIZE_HI], third_reg[BIT_SIZE_LO]}; // RL3
    assign parityEn = third_reg[BIT_PAR_EN];
    assign parityOdd = third_reg[BIT_PAR_ODD]; // RL28
    assign stopTwo = third_reg[BIT_STOP2];
    assign syncMode = third_reg[BIT_SYNC];
    assign syncMaster = syncMode && third_reg[BIT_MASTER];
    assign clockPol = third_reg[BIT_POL];

    // Character length from the size code
    always_comb begin
        case (charSize)
            SIZE_5: dataBits = 4'd5;
            SIZE_6: dataBits = 4'd6;
            SIZE_7: dataBits = 4'd7;
            SIZE_9: dataBits = 4'd9; // RL9
            default: dataBits = 4'd8;
        endcase
    end

    // Drop unused upper bits of the buffered character
    assign dataMask = 9'((10'h001 << dataBits) - 10'h001);
    assign maskedBuf = buf_reg & dataMask; // RL14

    // Baud-rate generator
    utxf_baud_gen #(
        .WIDTH(BAUD_WIDTH)
    ) u_baud (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .divisor(baud_reg),
        .reload(apbWrite && paddr == OFS_BAUD_LOW),
        .tick(baudTick)
    );

    // Ticks per bit for the asynchronous modes
    assign ticksPerBit = doubleSpeed_reg ? TICKS_DOUBLE : TICKS_NORMAL; // RL25

    // Two-stage synchroniser and edge history for the clock pin
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            xckS1_reg <= 1'b0;
            xckS2_reg <= 1'b0;
            xckS3_reg <= 1'b0;
        end else begin
            xckS1_reg <= xckIn;
            xckS2_reg <= xckS1_reg;
            xckS3_reg <= xckS2_reg;
        end
    end

    // Bit-change enable per clocking mode
    always_comb begin
        if (syncMaster) begin
            bitEn = baudTick && (xckOut == clockPol); // RL26
        end else if (syncMode) begin
            bitEn = clockPol ? (!xckS2_reg && xckS3_reg)
                             : (xckS2_reg && !xckS3_reg); // RL11
        end else begin
            bitEn = baudTick && (presc_reg == ticksPerBit); // RL25
        end
    end

    // Prescaler for asynchronous bits, restarted on an immediate load
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            presc_reg <= 4'h0;
        end else if (loadNow && txState == TX_IDLE) begin
            presc_reg <= 4'h0;
        end else if (baudTick) begin
            presc_reg <= (presc_reg >= ticksPerBit) ? 4'h0 : presc_reg + 4'h1;
        end
    end

    // Master clock out: half a bit per baud tick, pin taken in sync master
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            xckOut <= 1'b0;
            xckOe <= 1'b0;
        end else begin
            xckOe <= syncMaster && txOn_reg; // RL11
            if (!syncMaster) begin
                xckOut <= clockPol;
            end else if (baudTick && txOn_reg) begin
                xckOut <= !xckOut; // RL25
            end
        end
    end

    // Buffer to shifter hand-over and end of frame
    assign frameEnd = bitEn && ((txState == TX_STOP1 && !stopTwo) || txState == TX_STOP2);
    always_comb begin
        loadNow = 1'b0;
        if (bufFull_reg && txOn_reg) begin
            if (txState == TX_IDLE) begin
                loadNow = syncMode ? bitEn : 1'b1; // RL13
            end else begin
                loadNow = frameEnd; // RL13
            end
        end
    end

    // APB access phase commit
    assign apbWrite = psel && penable && pwrite && pready;

    // Frame sequencer and serial line
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            txState <= TX_IDLE;
            shift_reg <= 9'h000;
            bitCnt_reg <= 4'h0;
            parityBit_reg <= 1'b0;
            txdOut <= 1'b1;
        end else if (loadNow) begin
            txState <= TX_START;
            shift_reg <= maskedBuf;
            bitCnt_reg <= 4'h0;
            parityBit_reg <= (^maskedBuf) ^ parityOdd; // RL7
            txdOut <= 1'b0; // RL1
        end else if (bitEn) begin
            case (txState)
                TX_START: begin
                    txState <= TX_DATA;
                    txdOut <= shift_reg[0]; // RL24
                    shift_reg <= {1'b0, shift_reg[8:1]};
                    bitCnt_reg <= 4'h1;
                end
                TX_DATA: begin
                    if (bitCnt_reg == dataBits) begin
                        txState <= parityEn ? TX_PARITY : TX_STOP1; // RL8
                        txdOut <= parityEn ? parityBit_reg : 1'b1; // RL8
                    end else begin
                        txdOut <= shift_reg[0]; // RL24
                        shift_reg <= {1'b0, shift_reg[8:1]};
                        bitCnt_reg <= bitCnt_reg + 4'h1;
                    end
                end
                TX_PARITY: begin
                    txState <= TX_STOP1;
                    txdOut <= 1'b1; // RL2
                end
                TX_STOP1: begin
                    txState <= stopTwo ? TX_STOP2 : TX_IDLE; // RL5
                    txdOut <= 1'b1; // RL2
                end
                TX_STOP2: begin
                    txState <= TX_IDLE;
                    txdOut <= 1'b1;
                end
                default: begin
                    txState <= TX_IDLE;
                    txdOut <= 1'b1; // RL2
                end
            endcase
        end
    end

    // Transmit buffer; a data write beats a same-cycle hand-over
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            buf_reg <= 9'h000;
            bufFull_reg <= 1'b0;
        end else if (apbWrite && paddr == OFS_DATA) begin
            buf_reg <= {second_reg[BIT_NINTH], pwdata[7:0]}; // RL12
            bufFull_reg <= 1'b1; // RL16
        end else if (loadNow) begin
            bufFull_reg <= 1'b0; // RL16
        end
    end

    // Transmit-complete flag, set wins over either clear
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            txcFlag_reg <= 1'b0;
        end else if (frameEnd && !bufFull_reg) begin
            txcFlag_reg <= 1'b1; // RL18
        end else if (txCompleteAck
                     || (apbWrite && paddr == OFS_FIRST && pwdata[BIT_TXC])) begin
            txcFlag_reg <= 1'b0; // RL19
        end
    end

    // Effective enable: stays on until shifter and buffer drain
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            txOn_reg <= 1'b0;
            txdOe <= 1'b0;
        end else begin
            if (second_reg[BIT_TX_EN]) begin
                txOn_reg <= 1'b1;
            end else if (txState == TX_IDLE && !bufFull_reg) begin
                txOn_reg <= 1'b0; // RL21
            end
            txdOe <= second_reg[BIT_TX_EN] || txState != TX_IDLE
                     || bufFull_reg; // RL10
        end
    end

    // Interrupt request levels
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bufEmptyIrq <= 1'b0;
            txCompleteIrq <= 1'b0;
        end else begin
            bufEmptyIrq <= second_reg[BIT_BUF_IE] && !bufFull_reg; // RL17
            txCompleteIrq <= second_reg[BIT_TXC_IE] && txcFlag_reg; // RL20
        end
    end

    // Control register writes
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            doubleSpeed_reg <= 1'b0;
            second_reg <= RST_SECOND;
            third_reg <= RST_THIRD;
            baud_reg <= RST_BAUD;
        end else if (apbWrite) begin
            case (paddr)
                OFS_FIRST: doubleSpeed_reg <= pwdata[BIT_DOUBLE];
                OFS_SECOND: second_reg <= pwdata[7:0];
                OFS_THIRD: third_reg <= pwdata[7:0]; // RL3
                OFS_BAUD_LOW: baud_reg[7:0] <= pwdata[7:0];
                OFS_BAUD_HIGH: baud_reg[BAUD_WIDTH-1:8] <= pwdata[BAUD_WIDTH-9:0];
                default: baud_reg <= baud_reg;
            endcase
        end
    end

    // Read mux
    always_comb begin
        rdValue = 8'h00;
        addrHit = 1'b1;
        case (paddr)
            OFS_DATA: rdValue = 8'h00;
            OFS_FIRST: begin
                rdValue[BIT_TXC] = txcFlag_reg;
                rdValue[BIT_BUF_EMPTY] = !bufFull_reg; // RL16
                rdValue[BIT_DOUBLE] = doubleSpeed_reg;
            end
            OFS_SECOND: rdValue = second_reg;
            OFS_THIRD: rdValue = third_reg;
            OFS_BAUD_LOW: rdValue = baud_reg[7:0];
            OFS_BAUD_HIGH: rdValue = 8'(baud_reg[BAUD_WIDTH-1:8]);
            default: addrHit = 1'b0;
        endcase
    end

    // APB answer: one wait-free access phase after each setup
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addrHit;
            if (psel && !penable && !pwrite) begin
                prdata <= {24'h00_0000, rdValue};
            end
        end
    end

    // Checks
    sequence s_lastData;
        txState == TX_DATA && bitEn && bitCnt_reg == dataBits && !loadNow;
    endsequence
    sequence s_drained;
        !second_reg[BIT_TX_EN] && txState == TX_IDLE && !bufFull_reg;
    endsequence

    property p_startLow;
        @(posedge sys_clk) disable iff (!rst_n) txState == TX_START |-> !txdOut;
    endproperty
    a_startLow: assert property (p_startLow) else $error("start bit not low"); // RL1
    property p_idleHigh;
        @(posedge sys_clk) disable iff (!rst_n)
        (txState == TX_IDLE || txState == TX_STOP1 || txState == TX_STOP2) |-> txdOut;
    endproperty
    a_idleHigh: assert property (p_idleHigh) else $error("line not high at rest"); // RL2
    property p_stopCount;
        @(posedge sys_clk) disable iff (!rst_n)
        (txState == TX_STOP1 && bitEn && !loadNow) |=>
            (txState == (stopTwo ? TX_STOP2 : TX_IDLE));
    endproperty
    a_stopCount: assert property (p_stopCount) else $error("wrong stop count"); // RL5
    property p_parityValue;
        @(posedge sys_clk) disable iff (!rst_n)
        loadNow |=> parityBit_reg == ((^$past(maskedBuf)) ^ $past(parityOdd));
    endproperty
    a_parityValue: assert property (p_parityValue) else $error("parity wrong"); // RL7
    property p_parityPlace;
        @(posedge sys_clk) disable iff (!rst_n)
        s_lastData |=> (txState == (parityEn ? TX_PARITY : TX_STOP1)) && txdOut == (parityEn ? parityBit_reg : 1'b1);
    endproperty
    a_parityPlace: assert property (p_parityPlace) else $error("parity misplaced"); // RL8
    property p_bufIrq;
        @(posedge sys_clk) disable iff (!rst_n)
        (second_reg[BIT_BUF_IE] && !bufFull_reg) |=> bufEmptyIrq;
    endproperty
    a_bufIrq: assert property (p_bufIrq) else $error("buffer-empty request missing"); // RL17
    property p_txcSet;
        @(posedge sys_clk) disable iff (!rst_n)
        (frameEnd && !bufFull_reg) |=> txcFlag_reg ##1 (txCompleteIrq == second_reg[BIT_TXC_IE]);
    endproperty
    a_txcSet: assert property (p_txcSet) else $error("complete flag not set"); // RL18
    property p_release;
        @(posedge sys_clk) disable iff (!rst_n)
        s_drained |=> !txOn_reg && !txdOe;
    endproperty
    a_release: assert property (p_release) else $error("pin not released"); // RL21
    property p_holdPin;
        @(posedge sys_clk) disable iff (!rst_n)
        txState != TX_IDLE |=> txdOe;
    endproperty
    a_holdPin: assert property (p_holdPin) else $error("pin dropped mid frame"); // RL10
endmodule
`default_nettype wire

/* File: utxf_rx_model.sv */
// Remote serial receiver model that decodes frames from the line.
// Assumes the line idles high and bit time is given in system clocks.
`timescale 1ns/100ps
`default_nettype none
module utxf_rx_model (
    // Clock and line
    input wire logic sys_clk,
    input wire logic lineIn,
    // Expected format
    input wire logic [15:0] bitLen,
    input wire logic [3:0] nBits,
    input wire logic parEn,
    input wire logic twoStops,
    // Last frame seen
    output logic [8:0] rxData,
    output logic rxPar,
    output logic [1:0] rxStop,
    output logic [7:0] frames
);
    // Mid-bit sampling after each falling start edge
    initial begin
        logic [8:0] d;
        rxData = 9'h000;
        rxPar = 1'h0;
        rxStop = 2'h0;
        frames = 8'h00;
        forever begin
            @(negedge lineIn);
            repeat (bitLen / 2) @(posedge sys_clk);
            if (lineIn === 1'h0) begin
                d = 9'h000;
                for (int i = 0; i < nBits; i++) begin
                    repeat (bitLen) @(posedge sys_clk);
                    d[i] = lineIn;
                end
                if (parEn) begin
                    repeat (bitLen) @(posedge sys_clk);
                    rxPar = lineIn;
                end
                repeat (bitLen) @(posedge sys_clk);
                rxStop = {1'h0, lineIn};
                if (twoStops) begin
                    repeat (bitLen) @(posedge sys_clk);
                    rxStop[1] = lineIn;
                end
                rxData = d;
                frames = frames + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

/* File: test_uart_transmitter_frame_format.sv */
// Bench for the serial transmitter: APB tasks set formats and send data,
// the receiver model decodes the line. Assumes one 125 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module test_uart_transmitter_frame_format import utxf_pkg::*;;
    typedef struct packed {
        logic [2:0] size;
        logic par;
        logic odd;
        logic stop2;
        logic dbl;
        logic sync;
        logic [11:0] div;
        logic [8:0] data;
    } utxf_cfg_t;
    // Formats: size, parity, odd, two stops, double, sync, divisor, data
    utxf_cfg_t cfgs [6] = '{
        '{SIZE_8, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 12'h000, 9'h0A5},
        '{SIZE_5, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 12'h000, 9'h0F6},
        '{SIZE_6, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 12'h001, 9'h02D},
        '{SIZE_7, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 12'h000, 9'h0D3},
        '{SIZE_9, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 12'h000, 9'h1C4},
        '{SIZE_8, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 12'h003, 9'h05A}
    };
    logic sys_clk = 1'h0;
    logic rst_n = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic txCompleteAck = 1'h0;
    logic xckIn = 1'h0;
    logic xckRun = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdData;
    logic pready, pslverr, bufEmptyIrq, txCompleteIrq, txdOut, txdOe, xckOut, xckOe;
    logic rdErr, serialLine, rxPar;
    logic [15:0] bitLen = 16'h0010;
    logic [3:0] nBits = 4'h8;
    logic parEn = 1'h0;
    logic twoStops = 1'h0;
    logic [8:0] rxData;
    logic [1:0] rxStop;
    logic [7:0] frames;
    logic [7:0] got = 8'h00;
    int numErrors = 0;
    int checked = 0;
    int cycles = 0;

    utxf_top #(.BAUD_WIDTH(12)) i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bufEmptyIrq(bufEmptyIrq),
        .txCompleteIrq(txCompleteIrq), .txCompleteAck(txCompleteAck),
        .txdOut(txdOut), .txdOe(txdOe), .xckIn(xckIn), .xckOut(xckOut), .xckOe(xckOe)
    );
    utxf_rx_model i_rx (
        .sys_clk(sys_clk), .lineIn(serialLine), .bitLen(bitLen), .nBits(nBits),
        .parEn(parEn), .twoStops(twoStops), .rxData(rxData), .rxPar(rxPar),
        .rxStop(rxStop), .frames(frames)
    );

    // Clock and pulled-up serial pin
    always #4 sys_clk = ~sys_clk;
    // External slave clock, eight system clocks a period, toggling on falling system clock edges
    always #32 xckIn = xckRun ? ~xckIn : 1'h0;
    assign serialLine = txdOe ? txdOut : 1'h1;

    // Hang guard, well above the expected run length
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            numErrors++;
            giveVerdict();
        end
    end

    task automatic giveVerdict();
        if (numErrors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checked++;
        if (seen !== exp) begin
            numErrors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer, then one idle edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        @(posedge sys_clk);
        for (n = 0; n < 20 && pready !== 1'h1; n++) @(posedge sys_clk);
        chk("pready", 1, pready);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge sys_clk);
    endtask

    // Program a frame format with transmitter and both enables on
    task automatic setup(input utxf_cfg_t c);
        nBits = (c.size == SIZE_9) ? 4'h9 : {1'h0, c.size} + 4'h5;
        bitLen = 16'(c.div + 12'h001) * (c.sync ? 16'h0002 : c.dbl ? 16'h0008 : 16'h0010);
        parEn = c.par;
        twoStops = c.stop2;
        apb(1'h1, OFS_THIRD, {24'h0, c.sync, c.sync, c.par, c.odd, c.stop2, c.size[1:0], 1'h0});
        apb(1'h1, OFS_FIRST, {24'h0, 6'h10, c.dbl, 1'h0});
        apb(1'h1, OFS_BAUD_HIGH, {28'h0, c.div[11:8]});
        apb(1'h1, OFS_BAUD_LOW, {24'h0, c.div[7:0]});
        apb(1'h1, OFS_SECOND, {24'h0, 5'h0D, c.size[2], 1'h0, c.data[8]});
    endtask

    // Wait for the next decoded frame and compare its fields
    task automatic frame(input utxf_cfg_t c, input logic [8:0] d);
        logic [8:0] m;
        int n;
        m = 9'h1FF >> (4'h9 - nBits);
        got = got + 8'h01;
        for (n = 0; n < 9000 && frames !== got; n++) @(posedge sys_clk);
        chk("frames", got, frames);
        chk("data", d & m, rxData);
        if (c.par) chk("parity", ^(d & m) ^ c.odd, rxPar);
        chk("stops", {c.stop2, 1'h1}, rxStop);
    endtask

    // Poll until the complete flag shows
    task automatic done();
        int n;
        rdData = 32'h0;
        for (n = 0; n < 300 && rdData[BIT_TXC] !== 1'h1; n++) apb(1'h0, OFS_FIRST, 32'h0);
        chk("complete", 1, rdData[BIT_TXC]);
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'h1;
        @(posedge sys_clk);
        chk("txdOe", 0, txdOe);
        chk("txdOut", 1, txdOut);
        chk("xckOe", 0, xckOe);
        apb(1'h0, OFS_FIRST, 32'h0);
        chk("first", 32'h20, rdData);
        apb(1'h0, OFS_SECOND, 32'h0);
        chk("second", {24'h0, RST_SECOND}, rdData);
        apb(1'h0, OFS_THIRD, 32'h0);
        chk("third", {24'h0, RST_THIRD}, rdData);
        apb(1'h0, 8'h18, 32'h0);
        chk("slverr", 1, rdErr);
        chk("unmapped", 0, rdData);
        for (int i = 0; i < 6; i++) begin
            setup(cfgs[i]);
            // Let the enable reach the pins, then look between edges
            repeat (2) @(posedge sys_clk);
            @(negedge sys_clk);
            chk("txdOe", 1, txdOe);
            chk("xckOe", cfgs[i].sync, xckOe);
            @(posedge sys_clk);
            apb(1'h1, OFS_DATA, {24'h0, cfgs[i].data[7:0]});
            frame(cfgs[i], cfgs[i].data);
            done();
            chk("txcIrq", 1, txCompleteIrq);
        end
        // Slave clocking: the clock pin paces the bits
        xckRun <= 1'h1;
        setup(cfgs[5]);
        apb(1'h1, OFS_THIRD, 32'h46);
        apb(1'h1, OFS_DATA, {24'h0, cfgs[5].data[7:0]});
        frame(cfgs[5], cfgs[5].data);
        done();
        chk("xckOe", 0, xckOe);
        chk("xckOut", 0, xckOut);
        xckRun <= 1'h0;
        // Second character waits in the buffer
        setup(cfgs[0]);
        apb(1'h1, OFS_DATA, 32'h3C);
        apb(1'h1, OFS_DATA, 32'hC3);
        apb(1'h0, OFS_FIRST, 32'h0);
        chk("first", 32'h00, rdData);
        chk("bufIrq", 0, bufEmptyIrq);
        frame(cfgs[0], 9'h03C);
        frame(cfgs[0], 9'h0C3);
        done();
        chk("bufIrq", 1, bufEmptyIrq);
        // Serviced interrupt clears the flag
        txCompleteAck <= 1'h1;
        @(posedge sys_clk);
        txCompleteAck <= 1'h0;
        apb(1'h0, OFS_FIRST, 32'h0);
        chk("first", 32'h20, rdData);
        chk("txcIrq", 0, txCompleteIrq);
        // Disable while a frame is in flight
        apb(1'h1, OFS_DATA, 32'h81);
        apb(1'h1, OFS_SECOND, 32'h0);
        chk("txdOe", 1, txdOe);
        frame(cfgs[0], 9'h081);
        done();
        chk("txdOe", 0, txdOe);
        giveVerdict();
    end
endmodule
`default_nettype wire
